// File: hw/tcr_dev.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_dev import tcr_pkg::*; (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Sync reset, low
  tcr_link_if.dev link, // Bus pins
  input wire logic [15:0] temp_i, // Temperature result
  input wire logic [15:0] cfg_i, // Config, flags low
  input wire logic [RTC_N*8-1:0] rtc_i, // Clock regs, seconds low
  output logic [7:0] cmd_o, // Selected command
  output logic [7:0] ptr_o, // Clock pointer
  output logic [7:0] wr_byte_o, // Written data byte
  output logic wr_stb_o // Pulse per data byte
);
  typedef enum logic [2:0] {D_IDLE, D_RECV, D_ACK, D_SEND, D_MACK,
                            D_WAIT} tcr_dst_t;
  typedef enum logic [1:0] {P_ADDR, P_CMD, P_PTR, P_DATA} tcr_ph_t;

  // ****************************************
  // Pin synchronisers and bus events
  // ****************************************
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic scl_d_r;
  logic sda_d_r;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic sda;

  // Two stages, then a third for edge finding
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], link.scl};
      sda_s_r <= {sda_s_r[0], link.sda};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  // START and STOP are data edges while the clock stays high
  assign sda = sda_s_r[1];
  assign rise = scl_s_r[1] & ~scl_d_r;
  assign fall = ~scl_s_r[1] & scl_d_r;
  assign start = scl_s_r[1] & scl_d_r & ~sda & sda_d_r;
  assign stop = scl_s_r[1] & scl_d_r & sda & ~sda_d_r;

  // ****************************************
  // Protocol engine
  // ****************************************
  tcr_dst_t st_r, st_nxt;
  tcr_ph_t ph_r, ph_nxt;
  logic rw_r, rw_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic oe_r, oe_nxt;
  logic ack_r, ack_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic idx_r, idx_nxt;
  logic [7:0] wb_r, wb_nxt;
  logic stb_r, stb_nxt;
  logic [7:0] tx_byte;
  logic [7:0] ptr_inc;

  // Clock pointer walks seconds to year, then wraps to seconds
  assign ptr_inc = (ptr_r >= PTR_LAST) ? PTR_SEC : ptr_r + 8'h01; // see RL9

  // Byte to send from command, byte index and pointer
  always_comb begin
    tx_byte = 8'hFF;
    case (cmd_r)
      CMD_TEMP: tx_byte = idx_r ? temp_i[7:0] : temp_i[15:8]; // see RL4
      CMD_CFG: tx_byte = idx_r ? cfg_i[7:0] : cfg_i[15:8]; // see RL11
      CMD_CLK: begin
        // Pointer 00h seconds, 01h minutes, then onward
        if (ptr_r < 8'(RTC_N)) begin
          tx_byte = rtc_i[{ptr_r[2:0], 3'b000} +: 8]; // see RL8, see RL15
        end
      end
      default: tx_byte = 8'hFF;
    endcase
  end

  // Next state; START and STOP override any byte in flight
  always_comb begin
    st_nxt = st_r;
    ph_nxt = ph_r;
    rw_nxt = rw_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    oe_nxt = oe_r;
    ack_nxt = ack_r;
    cmd_nxt = cmd_r;
    ptr_nxt = ptr_r;
    idx_nxt = idx_r;
    wb_nxt = wb_r;
    stb_nxt = 1'b0;
    if (stop) begin
      st_nxt = D_IDLE; // see RL16
      oe_nxt = 1'b0;
    end else if (start) begin
      // Command and pointer stay as they are across a repeat
      st_nxt = D_RECV; // see RL12
      ph_nxt = P_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        D_RECV: begin
          if (rise) begin
            sh_nxt = {sh_r[6:0], sda};
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall && cnt_r == 4'h8) begin
            cnt_nxt = 4'h0;
            if (ph_r == P_ADDR && sh_r[7:1] != DEV_ADDR7) begin
              st_nxt = D_WAIT; // Not us: stay off the bus
            end else begin
              st_nxt = D_ACK; // see RL1, see RL2
              oe_nxt = 1'b1;
              case (ph_r)
                P_ADDR: begin
                  rw_nxt = sh_r[0];
                  idx_nxt = 1'b0;
                end
                P_CMD: cmd_nxt = sh_r; // see RL3, see RL7, see RL10
                P_PTR: ptr_nxt = sh_r; // see RL7
                default: begin
                  wb_nxt = sh_r;
                  stb_nxt = 1'b1;
                  if (cmd_r == CMD_CLK) begin
                    ptr_nxt = ptr_inc;
                  end
                end
              endcase
            end
          end
        end
        D_ACK: begin
          if (fall) begin
            cnt_nxt = 4'h0;
            if (ph_r == P_ADDR && rw_r) begin
              // First bit goes out as soon as the acknowledge ends
              st_nxt = D_SEND;
              sh_nxt = tx_byte;
              oe_nxt = ~tx_byte[7];
            end else begin
              st_nxt = D_RECV;
              oe_nxt = 1'b0;
              case (ph_r)
                P_ADDR: ph_nxt = P_CMD;
                P_CMD: ph_nxt = (cmd_r == CMD_CLK) ? P_PTR : P_DATA; // see RL7
                default: ph_nxt = P_DATA;
              endcase
            end
          end
        end
        D_SEND: begin
          if (rise) begin
            cnt_nxt = cnt_r + 4'h1;
          end else if (fall) begin
            if (cnt_r == 4'h8) begin
              st_nxt = D_MACK;
              oe_nxt = 1'b0;
              ack_nxt = 1'b0;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = ~sh_r[6];
            end
          end
        end
        D_MACK: begin
          if (rise) begin
            if (!sda) begin
              // Advance now so the next byte is ready at the fall
              ack_nxt = 1'b1; // see RL5
              idx_nxt = 1'b1;
              if (cmd_r == CMD_CLK) begin
                ptr_nxt = ptr_inc; // see RL9
              end
            end else begin
              st_nxt = D_WAIT; // see RL6, see RL14, see RL16
            end
          end else if (fall && ack_r) begin
            st_nxt = D_SEND;
            cnt_nxt = 4'h0;
            sh_nxt = tx_byte;
            oe_nxt = ~tx_byte[7];
          end
        end
        default: oe_nxt = 1'b0;
      endcase
    end
  end

  // Register stage of the engine
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= D_IDLE;
      ph_r <= P_ADDR;
      rw_r <= 1'b0;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      oe_r <= 1'b0;
      ack_r <= 1'b0;
      cmd_r <= 8'h00;
      ptr_r <= PTR_SEC;
      idx_r <= 1'b0;
      wb_r <= 8'h00;
      stb_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      ph_r <= ph_nxt;
      rw_r <= rw_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      oe_r <= oe_nxt;
      ack_r <= ack_nxt;
      cmd_r <= cmd_nxt;
      ptr_r <= ptr_nxt;
      idx_r <= idx_nxt;
      wb_r <= wb_nxt;
      stb_r <= stb_nxt;
    end
  end

  // Outputs straight from flops
  assign link.sda_oe_d = oe_r;
  assign cmd_o = cmd_r;
  assign ptr_o = ptr_r;
  assign wr_byte_o = wb_r;
  assign wr_stb_o = stb_r;
endmodule : tcr_dev
`default_nettype wire

// File: hw/tcr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Read data FIFO
// ****************************************
module tcr_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Sync reset, low
  input wire logic in_valid_i, // Push request
  output logic in_ready_o, // Space left
  input wire logic [W-1:0] in_data_i, // Push data
  output logic out_valid_o, // Data present
  input wire logic out_ready_i, // Pop request
  output logic [W-1:0] out_data_o // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] n_r, n_nxt;
  logic push;
  logic pop;
  logic vld_r, vld_nxt;
  logic [W-1:0] dat_r, dat_nxt;

  // Head word and valid are registered so the read side sees flop outputs
  assign in_ready_o = n_r != (AW+1)'(DEPTH);
  assign out_valid_o = vld_r;
  assign out_data_o = dat_r;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Pointers wrap at DEPTH, which need not be a power of two
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    n_nxt = n_r + (AW+1)'(push) - (AW+1)'(pop);
    if (push) begin
      wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
    end
    vld_nxt = n_nxt != '0;
    // A push that becomes the head bypasses the memory
    dat_nxt = (push && n_r == (AW+1)'(pop)) ? in_data_i : mem[rp_nxt];
  end

  // Storage has no reset; counts guard it
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
    if (!rst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
      n_r <= '0;
      vld_r <= 1'b0;
      dat_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      n_r <= n_nxt;
      vld_r <= vld_nxt;
      dat_r <= dat_nxt;
    end
  end
endmodule : tcr_fifo

// ****************************************
// Bus master end
// ****************************************
module tcr_host import tcr_pkg::*; (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Sync reset, low
  tcr_link_if.host link, // Bus pins
  input wire logic req_i, // Start sequence, taken idle
  input wire logic [7:0] cmd_i, // Command byte
  input wire logic ptr_en_i, // Send pointer byte
  input wire logic [7:0] ptr_i, // Pointer byte
  input wire logic [3:0] rd_len_i, // Bytes to read, 0 as 1
  output logic busy_o, // Sequence running
  output logic done_o, // Pulse at end
  output logic err_o, // Address or byte refused
  output logic rd_valid_o, // Read byte present
  input wire logic rd_ready_i, // Read byte taken
  output logic [7:0] rd_data_o // Read byte
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_WR, H_RD,
                            H_STOP} tcr_hst_t;
  typedef enum logic [1:0] {S_ADDRW, S_CMD, S_PTR, S_ADDRR} tcr_step_t;

  logic [1:0] sda_s_r;
  logic [QTR_W-1:0] tk_r;
  logic tick;
  logic stall;
  logic in_ready;
  tcr_hst_t st_r, st_nxt;
  tcr_step_t sp_r, sp_nxt;
  logic [1:0] q_r, q_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic scl_r, scl_nxt, sda_r, sda_nxt;
  logic ack_r, ack_nxt;
  logic [3:0] len_r, len_nxt;
  logic [7:0] cmd_r, cmd_nxt, ptr_r, ptr_nxt;
  logic pen_r, pen_nxt, busy_r, busy_nxt, err_r, err_nxt;
  logic done_r, done_nxt, push_r, push_nxt;
  logic [7:0] pd_r, pd_nxt;

  // Data pin through two flops; free quarter-bit timer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sda_s_r <= 2'h3;
      tk_r <= '0;
    end else begin
      sda_s_r <= {sda_s_r[0], link.sda};
      tk_r <= tick ? '0 : tk_r + QTR_W'(1);
    end
  end

  assign tick = tk_r == QTR_W'(QTR_CYC - 1);
  // Hold the clock low before a read byte while the FIFO is full
  assign stall = st_r == H_RD && bit_r == 4'h0 && q_r == 2'h0 && !in_ready;

  // Sequence: START, address, command, pointer, START, address, reads
  always_comb begin
    st_nxt = st_r;
    sp_nxt = sp_r;
    q_nxt = q_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    scl_nxt = scl_r;
    sda_nxt = sda_r;
    ack_nxt = ack_r;
    len_nxt = len_r;
    cmd_nxt = cmd_r;
    ptr_nxt = ptr_r;
    pen_nxt = pen_r;
    busy_nxt = busy_r;
    err_nxt = err_r;
    done_nxt = 1'b0;
    push_nxt = 1'b0;
    pd_nxt = pd_r;
    if (st_r == H_IDLE) begin
      if (req_i) begin
        st_nxt = H_START;
        sp_nxt = S_ADDRW;
        q_nxt = 2'h0;
        cmd_nxt = cmd_i;
        ptr_nxt = ptr_i;
        pen_nxt = ptr_en_i;
        len_nxt = (rd_len_i == 4'h0) ? 4'h1 : rd_len_i; // see RL14
        busy_nxt = 1'b1;
        err_nxt = 1'b0;
      end
    end else if (tick && !stall) begin
      q_nxt = q_r + 2'h1;
      case (st_r)
        H_START: begin
          // Also serves as repeated START from a low clock
          case (q_r)
            2'h0: begin
              sda_nxt = 1'b0;
              scl_nxt = 1'b1;
            end
            2'h1: scl_nxt = 1'b0;
            2'h2: sda_nxt = 1'b1;
            default: begin
              scl_nxt = 1'b1;
              st_nxt = H_WR;
              bit_nxt = 4'h0;
              sh_nxt = (sp_r == S_ADDRR) ? ADDR_RD : ADDR_WR; // see RL1
            end
          endcase
        end
        H_WR: begin
          case (q_r)
            2'h0: sda_nxt = (bit_r == 4'h8) ? 1'b0 : ~sh_r[7];
            2'h1: scl_nxt = 1'b0;
            2'h2: ack_nxt = ~sda_s_r[1];
            default: begin
              scl_nxt = 1'b1;
              bit_nxt = bit_r + 4'h1;
              sh_nxt = {sh_r[6:0], 1'b0};
              if (bit_r == 4'h8) begin
                bit_nxt = 4'h0;
                if (!ack_r) begin
                  err_nxt = 1'b1;
                  st_nxt = H_STOP;
                end else begin
                  case (sp_r)
                    S_ADDRW: begin
                      sp_nxt = S_CMD;
                      sh_nxt = cmd_r; // see RL3, see RL10
                    end
                    S_CMD: begin
                      if (pen_r) begin
                        sp_nxt = S_PTR;
                        sh_nxt = ptr_r; // see RL7
                      end else begin
                        sp_nxt = S_ADDRR;
                        st_nxt = H_START; // see RL12
                      end
                    end
                    S_PTR: begin
                      sp_nxt = S_ADDRR;
                      st_nxt = H_START; // see RL12
                    end
                    default: st_nxt = H_RD;
                  endcase
                end
              end
            end
          endcase
        end
        H_RD: begin
          case (q_r)
            // Acknowledge while more is wanted, else not
            2'h0: sda_nxt = (bit_r == 4'h8) && len_r != 4'h1; // see RL5, see RL6
            2'h1: scl_nxt = 1'b0;
            2'h2: begin
              if (bit_r != 4'h8) begin
                sh_nxt = {sh_r[6:0], sda_s_r[1]};
              end
              if (bit_r == 4'h7) begin
                push_nxt = 1'b1;
                pd_nxt = {sh_r[6:0], sda_s_r[1]};
              end
            end
            default: begin
              scl_nxt = 1'b1;
              bit_nxt = bit_r + 4'h1;
              if (bit_r == 4'h8) begin
                bit_nxt = 4'h0;
                len_nxt = len_r - 4'h1;
                if (len_r == 4'h1) begin
                  st_nxt = H_STOP;
                end
              end
            end
          endcase
        end
        default: begin
          // STOP: data rises while the clock is high
          case (q_r)
            2'h0: begin
              sda_nxt = 1'b1;
              scl_nxt = 1'b1;
            end
            2'h1: scl_nxt = 1'b0;
            2'h2: sda_nxt = 1'b0; // see RL13
            default: begin
              st_nxt = H_IDLE;
              busy_nxt = 1'b0;
              done_nxt = 1'b1;
            end
          endcase
        end
      endcase
    end
  end

  // Register stage of the sequencer
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r <= H_IDLE;
      sp_r <= S_ADDRW;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      scl_r <= 1'b0;
      sda_r <= 1'b0;
      ack_r <= 1'b0;
      len_r <= 4'h0;
      cmd_r <= 8'h00;
      ptr_r <= 8'h00;
      pen_r <= 1'b0;
      busy_r <= 1'b0;
      err_r <= 1'b0;
      done_r <= 1'b0;
      push_r <= 1'b0;
      pd_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      sp_r <= sp_nxt;
      q_r <= q_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      scl_r <= scl_nxt;
      sda_r <= sda_nxt;
      ack_r <= ack_nxt;
      len_r <= len_nxt;
      cmd_r <= cmd_nxt;
      ptr_r <= ptr_nxt;
      pen_r <= pen_nxt;
      busy_r <= busy_nxt;
      err_r <= err_nxt;
      done_r <= done_nxt;
      push_r <= push_nxt;
      pd_r <= pd_nxt;
    end
  end

  // Room is checked before each byte, so a push always fits
  tcr_fifo #(.W(8), .DEPTH(8)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(push_r),
    .in_ready_o(in_ready),
    .in_data_i(pd_r),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o(rd_data_o)
  );

  assign link.scl_oe_m = scl_r;
  assign link.sda_oe_m = sda_r;
  assign busy_o = busy_r;
  assign done_o = done_r;
  assign err_o = err_r;
endmodule : tcr_host
`default_nettype wire

// File: hw/tcr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Two-wire link, open drain with pull-ups
// ****************************************
interface tcr_link_if;
  logic scl_oe_m;
  logic sda_oe_m;
  logic sda_oe_d;
  logic scl;
  logic sda;
  // An enabled driver pulls the line low, otherwise the pull-up wins
  assign scl = ~scl_oe_m;
  assign sda = ~(sda_oe_m | sda_oe_d);
  modport host (output scl_oe_m, output sda_oe_m, input sda);
  modport dev (output sda_oe_d, input scl, input sda);
endinterface : tcr_link_if
`default_nettype wire

// File: hw/tcr_pkg.sv
// Functional notes
// RL1: Address byte 9Eh writes, 9Fh reads; acknowledged.
// RL2: Device acknowledges every written byte.
// RL3: Command AAh selects temperature result.
// RL4: Temperature sent MSB first, LSB second.
// RL5: Master acknowledges bytes when wanting more.
// RL6: Master not-acknowledges final byte, ending transmission.
// RL7: Command C0h, next byte is clock pointer.
// RL8: Pointer 01h returns minutes first.
// RL9: Clock read advances pointer each byte; the code advances it only on a master acknowledge, not after the final byte.
// RL10: Command ACh selects configuration register.
// RL11: Configuration read returns upper, then flag byte.
// RL12: Repeated START keeps command and pointer.
// RL13: Master ends sequence with STOP.
// RL14: One temperature byte may be read alone.
// RL15: Pointer 00h selects seconds register.
// RL16: After not-acknowledge, release until START/STOP.
package tcr_pkg;
  // ****************************************
  // Bus addresses and commands
  // ****************************************
  localparam logic [7:0] ADDR_WR = 8'h9E;
  localparam logic [7:0] ADDR_RD = 8'h9F;
  localparam logic [6:0] DEV_ADDR7 = 7'h4F;
  localparam logic [7:0] CMD_TEMP = 8'hAA;
  localparam logic [7:0] CMD_CLK = 8'hC0;
  localparam logic [7:0] CMD_CFG = 8'hAC;
  localparam logic [7:0] PTR_SEC = 8'h00;
  localparam logic [7:0] PTR_MIN = 8'h01;
  localparam int RTC_N = 7;
  localparam logic [7:0] PTR_LAST = 8'h06;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 20;
  localparam int SCL_PERIOD_NS = 2500;
  // Quarter bit, rounded up so the period is never below the minimum
  localparam int QTR_CYC = (SCL_PERIOD_NS / 4 + CLK_NS - 1) / CLK_NS;
  localparam int QTR_W = $clog2(QTR_CYC);
endpackage : tcr_pkg

// File: test/tcr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tcr_monitor import tcr_pkg::*; (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Sync reset, low
  input wire logic scl_oe_m, // Host pulls SCL
  input wire logic sda_oe_m, // Host pulls SDA
  input wire logic sda_oe_d, // Device pulls SDA
  input wire logic scl, // SCL level
  input wire logic sda // SDA level
);
  // ****************************************
  // Bit decoder
  // ****************************************
  logic scl_r, sda_r, first_r, first_nxt, rd_r, rd_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt, hi_r, hi_nxt;
  logic rise, start;
  assign rise = scl && !scl_r;
  assign start = scl && scl_r && sda_r && !sda;

  // Bit slot, direction and SCL high time; the count saturates
  always_comb begin
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    first_nxt = first_r;
    rd_nxt = rd_r;
    hi_nxt = scl ? ((hi_r == 8'hFF) ? hi_r : hi_r + 8'h01) : 8'h00;
    if (start) begin
      bit_nxt = 4'h0;
      first_nxt = 1'b1;
    end else if (rise) begin
      sh_nxt = {sh_r[6:0], sda};
      bit_nxt = (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
      if (first_r && bit_r == 4'h7) rd_nxt = sda;
      if (bit_r == 4'h8) first_nxt = 1'b0;
    end
  end

  // Registers of the decoder
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      first_r <= 1'b0;
      rd_r <= 1'b0;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      hi_r <= 8'hFF; // Idle lines count as a long high phase
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      first_r <= first_nxt;
      rd_r <= rd_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      hi_r <= hi_nxt;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_rst_idle;
    $rose(rst_n_i) |-> !scl_oe_m && !sda_oe_m && !sda_oe_d;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("line driven just after reset");
  // Device data may only move while SCL has been low a while
  property p_dev_chg;
    $changed(sda_oe_d) |-> !scl && !$past(scl, 2);
  endproperty
  a_dev_chg: assert property (p_dev_chg)
    else $error("device SDA changed near SCL high");
  property p_scl_hi;
    $fell(scl) |-> hi_r >= 8'h3C;
  endproperty
  a_scl_hi: assert property (p_scl_hi)
    else $error("SCL high phase too short");
  property p_start;
    start |-> scl [*5];
  endproperty
  a_start: assert property (p_start)
    else $error("SCL fell too soon after START");
  property p_stop;
    scl && scl_r && !sda_r && sda |-> sda [*5];
  endproperty
  a_stop: assert property (p_stop)
    else $error("SDA not held high after STOP");
  property p_addr;
    rise && first_r && bit_r == 4'h7 |-> sh_r[6:0] == DEV_ADDR7;
  endproperty
  a_addr: assert property (p_addr)
    else $error("address byte differs from device address");
  property p_ack_wr;
    rise && bit_r == 4'h8 && (first_r || !rd_r) |-> !sda;
  endproperty
  a_ack_wr: assert property (p_ack_wr)
    else $error("written byte not acknowledged");
  // After the host refuses a byte the device must stay off the line
  property p_nack;
    rise && bit_r == 4'h8 && !first_r && rd_r && sda
      |-> ##66 !sda_oe_d [*8];
  endproperty
  a_nack: assert property (p_nack)
    else $error("device drove SDA after refusal");

  c_start: cover property (start);
  c_ack_rd: cover property (rise && bit_r == 4'h8 && rd_r && !sda);
  c_nack: cover property (rise && bit_r == 4'h8 && rd_r && sda);
endmodule : tcr_monitor
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import tcr_pkg::*;;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_i = 1'b0, ptr_en_i = 1'b0, rd_ready_i = 1'b0;
  logic [7:0] cmd_i = 8'h00, ptr_i = 8'h00;
  logic [3:0] rd_len_i = 4'h0;
  logic [15:0] temp_i = 16'h0000, cfg_i = 16'h0000;
  logic [RTC_N*8-1:0] rtc_i = '0;
  logic busy_o, done_o, err_o, rd_valid_o, wr_stb_o;
  logic [7:0] rd_data_o, cmd_o, ptr_o, wr_byte_o;
  int num_errors = 0, comparisons = 0, stb_cnt = 0, tn = 0;
  logic [31:0] seed = 32'hB55F1BC9;
  logic [7:0] exp_q[$];
  logic [7:0] pm = 8'h00;

  // Free running clock
  always #10 clk_i = ~clk_i;
  // Count data strobes of the device
  always @(posedge clk_i) if (wr_stb_o === 1'b1) stb_cnt++;

  tcr_link_if u_tcr_link_if();
  tcr_dev u_tcr_dev (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .link(u_tcr_link_if), .temp_i(temp_i), .cfg_i(cfg_i),
    .rtc_i(rtc_i), .cmd_o(cmd_o), .ptr_o(ptr_o),
    .wr_byte_o(wr_byte_o), .wr_stb_o(wr_stb_o));
  tcr_host u_tcr_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .link(u_tcr_link_if), .req_i(req_i), .cmd_i(cmd_i),
    .ptr_en_i(ptr_en_i), .ptr_i(ptr_i), .rd_len_i(rd_len_i),
    .busy_o(busy_o), .done_o(done_o), .err_o(err_o),
    .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i),
    .rd_data_o(rd_data_o));
  tcr_monitor u_tcr_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .scl_oe_m(u_tcr_link_if.scl_oe_m),
    .sda_oe_m(u_tcr_link_if.sda_oe_m),
    .sda_oe_d(u_tcr_link_if.sda_oe_d), .scl(u_tcr_link_if.scl),
    .sda(u_tcr_link_if.sda));

  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, s);
      num_errors++;
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  // One full sequence; stall holds the reader off to fill the buffer
  task automatic run(input logic [7:0] c, input logic pe,
                     input logic [7:0] p, input logic [3:0] len,
                     input int stall);
    int n;
    int s0;
    int nb;
    logic [7:0] q;
    logic [31:0] r;
    logic fin;
    r = rnd();
    temp_i <= r[15:0];
    cfg_i <= r[31:16];
    rtc_i <= {r[23:0], rnd()};
    @(posedge clk_i);
    // Model of the bytes due back and of the final pointer
    nb = (len == 4'h0) ? 1 : int'(len);
    if (c == CMD_CLK && pe) pm = p;
    for (int i = 0; i < nb; i++) begin
      case (c)
        CMD_TEMP: q = (i == 0) ? temp_i[15:8] : temp_i[7:0];
        CMD_CFG: q = (i == 0) ? cfg_i[15:8] : cfg_i[7:0];
        CMD_CLK: q = (pm < 8'h07) ? rtc_i[pm*8 +: 8] : 8'hFF;
        default: q = 8'hFF;
      endcase
      exp_q.push_back(q);
      if (c == CMD_CLK && i < nb - 1) begin
        pm = (pm == 8'h06) ? 8'h00 : pm + 8'h01;
      end
    end
    s0 = stb_cnt;
    req_i <= 1'b1;
    cmd_i <= c;
    ptr_en_i <= pe;
    ptr_i <= p;
    rd_len_i <= len;
    @(posedge clk_i);
    req_i <= 1'b0;
    fin = 1'b0;
    for (n = 0; n < 40000 && !(fin && exp_q.size() == 0); n++) begin
      @(posedge clk_i);
      if (done_o === 1'b1) fin = 1'b1;
      if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
        if (exp_q.size() == 0) check("extra byte", 16'h0000, 16'h0001);
        else check("read byte", 16'(exp_q.pop_front()),
                   16'(rd_data_o));
      end
      if (stall > 0 && n == stall) begin
        check("stalled busy", 16'h0001, 16'(busy_o));
        check("stalled valid", 16'h0001, 16'(rd_valid_o));
      end
      r = rnd();
      rd_ready_i <= (n < stall) ? 1'b0 : r[0];
    end
    if (n >= 40000) begin
      check("sequence end", 16'h0000, 16'h0001);
      give_verdict();
    end
    @(posedge clk_i);
    check("buffer empty", 16'h0000, 16'(rd_valid_o));
    check("error flag", 16'h0000, 16'(err_o));
    check("command", 16'(c), 16'(cmd_o));
    if (c == CMD_CLK) check("pointer", 16'(pm), 16'(ptr_o));
    else if (pe) check("data byte", 16'(p), 16'(wr_byte_o));
    check("strobes", (c != CMD_CLK && pe) ? 16'h0001 : 16'h0000,
          16'(stb_cnt - s0));
    tn++;
    $display("test %0d finished", tn);
  endtask : run

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    run(CMD_TEMP, 1'b0, 8'h00, 4'h2, 0);
    run(CMD_TEMP, 1'b0, 8'h00, 4'h0, 0);
    run(CMD_CLK, 1'b1, PTR_MIN, 4'h6, 0);
    run(CMD_CFG, 1'b1, 8'h5A, 4'h2, 0);
    run(CMD_CLK, 1'b1, PTR_SEC, 4'h9, 20000);
    run(8'h55, 1'b0, 8'h00, 4'h1, 0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
